// ### rtl/rxcfg_defines.svh
`ifndef RXCFG_DEFINES_SVH
`define RXCFG_DEFINES_SVH

// Register offsets on the serial control port.
`define RXCFG_ADDR_ADC_MODE 8'h7c
`define RXCFG_ADDR_FSADJ 8'h7d
`define RXCFG_ADDR_TRIM_CTRL 8'h7e
`define RXCFG_ADDR_I_TRIM_HI 8'h7f
`define RXCFG_ADDR_I_TRIM_LO 8'h80
`define RXCFG_ADDR_Q_TRIM_HI 8'h81
`define RXCFG_ADDR_Q_TRIM_LO 8'h82
`define RXCFG_ADDR_LOCK 8'h84
`define RXCFG_ADDR_UPDATE 8'hff

// Field positions.
`define RXCFG_TRIM_EN_BIT 6
`define RXCFG_FINE_BIT 5
`define RXCFG_AUXCML_BIT 4
`define RXCFG_CMBUF_DIS_BIT 0
`define RXCFG_CAL_EN_BIT 0
`define RXCFG_UPDATE_BIT 0
`define RXCFG_TX_LOCK_BIT 1
`define RXCFG_RX_LOCK_BIT 0

// Reset values.
`define RXCFG_RST_BYTE 8'h00
`define RXCFG_RST_FSADJ 5'h00
`define RXCFG_RST_TRIM 10'h000

`endif

// ### rtl/rxcfg_pkg.sv
package rxcfg_pkg;

  // Receive converter arrangement; Gray order along both -> I only -> Q only.
  typedef enum logic [1:0] {
    RXCFG_MODE_DUAL = 2'h0,
    RXCFG_MODE_I_ONLY = 2'h1,
    RXCFG_MODE_Q_ONLY = 2'h3
  } rxcfg_adc_mode_t;

endpackage : rxcfg_pkg

// ### rtl/rxcfg_trim_regs.sv
// Functional notes
// - Trim control bit 0 set disables the input common-mode buffer, clear keeps it active.
// - The 10-bit I trim word takes bits 9:2 from the first I trim register and bits 1:0 from bits 2:1 of the second.
// - The 10-bit Q trim word is laid out the same way across the two Q trim registers.
// - Both trim words leave the gain unchanged, driven as zero, unless the trim enable is set.
// - With the fine step bit set the trim step weight is halved.
// - Bit 0 of each second trim register enables that channel's calibration DAC.
// - The lock status register shows transmit loop lock on bit 1 and receive loop lock on bit 0, read only.
// - Only a 0-to-1 change of update bit 0 starts a transfer; rewriting 1 does nothing.
// - An update copies the staged settings into the active set in one clock and applies them.
// - The full-scale range follows a 5-bit full-scale adjust field.
// - One receive converter can be powered down with the interface in single-converter mode.
// - Trim control bit 6 enables gain calibration so the trim words apply.
// - Trim control bit 5 selects the fine trim step.
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_defines.svh"

module rxcfg_trim_regs
  import rxcfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_tx_delay_loop_locked,
  input wire logic i_rx_delay_loop_locked,
  output logic [7:0] o_reg_rdata,
  output logic o_cm_buffer_disable,
  output logic o_aux_cml_enable,
  output logic o_gain_trim_enable,
  output logic o_fine_trim_step,
  output logic [9:0] o_i_gain_trim_word,
  output logic [9:0] o_q_gain_trim_word,
  output logic o_i_cal_dac_enable,
  output logic o_q_cal_dac_enable,
  output logic [4:0] o_full_scale_adjust,
  output rxcfg_adc_mode_t o_adc_mode,
  output logic o_update_applied
);

  // Staged (global) register images.
  logic [7:0] mode_q;
  logic [4:0] fsadj_q;
  logic [7:0] ctrl_q;
  logic [7:0] i_hi_q;
  logic [7:0] i_lo_q;
  logic [7:0] q_hi_q;
  logic [7:0] q_lo_q;
  logic upd_bit_q;
  logic upd_go_q;
  logic [1:0] lock_meta_q;
  logic [1:0] lock_q;
  logic [9:0] i_word_d;
  logic [9:0] q_word_d;
  rxcfg_adc_mode_t mode_d;

  wire logic wr = i_ce & i_reg_wr_en;

  // Staged registers take writes at once; the converters never see them directly.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= `RXCFG_RST_BYTE;
      fsadj_q <= `RXCFG_RST_FSADJ;
      ctrl_q <= `RXCFG_RST_BYTE;
      i_hi_q <= `RXCFG_RST_BYTE;
      i_lo_q <= `RXCFG_RST_BYTE;
      q_hi_q <= `RXCFG_RST_BYTE;
      q_lo_q <= `RXCFG_RST_BYTE;
    end else if (wr) begin
      unique case (i_reg_addr)
        `RXCFG_ADDR_ADC_MODE: mode_q <= {6'h00, i_reg_wdata[1:0]};
        `RXCFG_ADDR_FSADJ: fsadj_q <= i_reg_wdata[4:0];
        `RXCFG_ADDR_TRIM_CTRL: ctrl_q <= {1'b0, i_reg_wdata[6:4], 3'h0, i_reg_wdata[0]};
        `RXCFG_ADDR_I_TRIM_HI: i_hi_q <= i_reg_wdata;
        `RXCFG_ADDR_I_TRIM_LO: i_lo_q <= {5'h00, i_reg_wdata[2:0]};
        `RXCFG_ADDR_Q_TRIM_HI: q_hi_q <= i_reg_wdata;
        `RXCFG_ADDR_Q_TRIM_LO: q_lo_q <= {5'h00, i_reg_wdata[2:0]};
        default: ;
      endcase
    end
  end

  // The update bit is stored so that rewriting 1 is not seen as a new edge.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      upd_bit_q <= 1'b0;
      upd_go_q <= 1'b0;
    end else if (i_ce) begin
      upd_go_q <= 1'b0;
      if (wr && i_reg_addr == `RXCFG_ADDR_UPDATE) begin
        upd_bit_q <= i_reg_wdata[`RXCFG_UPDATE_BIT];
        upd_go_q <= i_reg_wdata[`RXCFG_UPDATE_BIT] & ~upd_bit_q;
      end
    end
  end

  // Lock levels come from the analog loops, so they pass two flops first.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_meta_q <= 2'h0;
      lock_q <= 2'h0;
    end else if (i_ce) begin
      lock_meta_q <= {i_tx_delay_loop_locked, i_rx_delay_loop_locked};
      lock_q <= lock_meta_q;
    end
  end

  // Trim words are zeroed unless calibration is on, so a stale word can never bend the gain.
  always_comb begin
    i_word_d = {i_hi_q, i_lo_q[2:1]};
    q_word_d = {q_hi_q, q_lo_q[2:1]};
    if (!ctrl_q[`RXCFG_TRIM_EN_BIT]) begin
      i_word_d = `RXCFG_RST_TRIM;
      q_word_d = `RXCFG_RST_TRIM;
    end
    unique case (mode_q[1:0])
      2'h1: mode_d = RXCFG_MODE_I_ONLY;
      2'h3: mode_d = RXCFG_MODE_Q_ONLY;
      default: mode_d = RXCFG_MODE_DUAL;
    endcase
  end

  // Active (local) set: loaded in one clock, one cycle after the triggering write.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cm_buffer_disable <= 1'b0;
      o_aux_cml_enable <= 1'b0;
      o_gain_trim_enable <= 1'b0;
      o_fine_trim_step <= 1'b0;
      o_i_gain_trim_word <= `RXCFG_RST_TRIM;
      o_q_gain_trim_word <= `RXCFG_RST_TRIM;
      o_i_cal_dac_enable <= 1'b0;
      o_q_cal_dac_enable <= 1'b0;
      o_full_scale_adjust <= `RXCFG_RST_FSADJ;
      o_adc_mode <= RXCFG_MODE_DUAL;
      o_update_applied <= 1'b0;
    end else if (i_ce) begin
      o_update_applied <= upd_go_q;
      if (upd_go_q) begin
        o_cm_buffer_disable <= ctrl_q[`RXCFG_CMBUF_DIS_BIT];
        o_aux_cml_enable <= ctrl_q[`RXCFG_AUXCML_BIT];
        o_gain_trim_enable <= ctrl_q[`RXCFG_TRIM_EN_BIT];
        o_fine_trim_step <= ctrl_q[`RXCFG_FINE_BIT];
        o_i_gain_trim_word <= i_word_d;
        o_q_gain_trim_word <= q_word_d;
        o_i_cal_dac_enable <= i_lo_q[`RXCFG_CAL_EN_BIT];
        o_q_cal_dac_enable <= q_lo_q[`RXCFG_CAL_EN_BIT];
        o_full_scale_adjust <= fsadj_q;
        o_adc_mode <= mode_d;
      end
    end
  end

  // Read data is registered; unmapped offsets read as zero.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= `RXCFG_RST_BYTE;
    end else if (i_ce && i_reg_rd_en) begin
      unique case (i_reg_addr)
        `RXCFG_ADDR_ADC_MODE: o_reg_rdata <= mode_q;
        `RXCFG_ADDR_FSADJ: o_reg_rdata <= {3'h0, fsadj_q};
        `RXCFG_ADDR_TRIM_CTRL: o_reg_rdata <= ctrl_q;
        `RXCFG_ADDR_I_TRIM_HI: o_reg_rdata <= i_hi_q;
        `RXCFG_ADDR_I_TRIM_LO: o_reg_rdata <= i_lo_q;
        `RXCFG_ADDR_Q_TRIM_HI: o_reg_rdata <= q_hi_q;
        `RXCFG_ADDR_Q_TRIM_LO: o_reg_rdata <= q_lo_q;
        `RXCFG_ADDR_LOCK: o_reg_rdata <= {6'h00, lock_q};
        `RXCFG_ADDR_UPDATE: o_reg_rdata <= {7'h00, upd_bit_q};
        default: o_reg_rdata <= `RXCFG_RST_BYTE;
      endcase
    end
  end

  // Checks run on the system clock and stand down while reset is high.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_UPD_EDGE_ONLY: assert property (
    (i_ce && wr && i_reg_addr == `RXCFG_ADDR_UPDATE && upd_bit_q) |=> !upd_go_q)
    else $error("Update started while bit already set.");

  AST_UPD_RISE_STARTS: assert property (
    (i_ce && wr && i_reg_addr == `RXCFG_ADDR_UPDATE && !upd_bit_q && i_reg_wdata[0])
    ##1 i_ce |=> o_update_applied)
    else $error("Rising update did not apply.");

  AST_ACTIVE_HOLDS: assert property (
    (i_ce && !upd_go_q) |=> $stable(o_i_gain_trim_word) && $stable(o_full_scale_adjust)
    && $stable(o_cm_buffer_disable))
    else $error("Active setting changed without update.");

  AST_TRIM_GATED: assert property (
    !o_gain_trim_enable |-> (o_i_gain_trim_word == 10'h000 && o_q_gain_trim_word == 10'h000))
    else $error("Trim word active with calibration off.");

  AST_I_PACK: assert property (
    (i_ce && upd_go_q && ctrl_q[6]) |=> o_i_gain_trim_word == {$past(i_hi_q), $past(i_lo_q[2:1])})
    else $error("I trim word packed wrongly.");

  AST_Q_PACK: assert property (
    (i_ce && upd_go_q && ctrl_q[6]) |=> o_q_gain_trim_word == {$past(q_hi_q), $past(q_lo_q[2:1])})
    else $error("Q trim word packed wrongly.");

  AST_CTRL_COPY: assert property (
    (i_ce && upd_go_q) |=> (o_cm_buffer_disable == $past(ctrl_q[0]))
    && (o_fine_trim_step == $past(ctrl_q[5])) && (o_gain_trim_enable == $past(ctrl_q[6])))
    else $error("Control bits not copied on update.");

  AST_CAL_DAC: assert property (
    (i_ce && upd_go_q) |=> (o_i_cal_dac_enable == $past(i_lo_q[0]))
    && (o_q_cal_dac_enable == $past(q_lo_q[0])))
    else $error("Calibration DAC enable not copied.");

  AST_FSADJ: assert property (
    (i_ce && upd_go_q) |=> o_full_scale_adjust == $past(fsadj_q))
    else $error("Full-scale adjust not copied.");

  AST_LOCK_READ: assert property (
    (i_ce && i_reg_rd_en && i_reg_addr == `RXCFG_ADDR_LOCK) |=> o_reg_rdata == {6'h00, $past(lock_q)})
    else $error("Lock status read wrong.");

  AST_MODE_LEGAL: assert property (
    o_adc_mode inside {RXCFG_MODE_DUAL, RXCFG_MODE_I_ONLY, RXCFG_MODE_Q_ONLY})
    else $error("Illegal converter mode.");

  // Staged captures: each offset keeps only its defined bits, so reserved bits always read zero.
  AST_MODE_STAGED: assert property (
    (wr && i_reg_addr == `RXCFG_ADDR_ADC_MODE) |=> mode_q == ($past(i_reg_wdata) & 8'h03))
    else $error("Converter mode not staged.");

  AST_FSADJ_STAGED: assert property (
    (wr && i_reg_addr == `RXCFG_ADDR_FSADJ) |=> {3'h0, fsadj_q} == ($past(i_reg_wdata) & 8'h1f))
    else $error("Full-scale adjust not staged.");

  AST_CTRL_STAGED: assert property (
    (wr && i_reg_addr == `RXCFG_ADDR_TRIM_CTRL) |=> ctrl_q == ($past(i_reg_wdata) & 8'h71))
    else $error("Trim control not staged.");

  AST_I_LO_STAGED: assert property (
    (wr && i_reg_addr == `RXCFG_ADDR_I_TRIM_LO) |=> i_lo_q == ($past(i_reg_wdata) & 8'h07))
    else $error("I trim low byte not staged.");

  AST_Q_LO_STAGED: assert property (
    (wr && i_reg_addr == `RXCFG_ADDR_Q_TRIM_LO) |=> q_lo_q == ($past(i_reg_wdata) & 8'h07))
    else $error("Q trim low byte not staged.");

  // Trigger path: only a write to the update offset starts a transfer, and the flag lasts one cycle.
  AST_UPD_NEEDS_WRITE: assert property (
    (i_ce && !(wr && i_reg_addr == `RXCFG_ADDR_UPDATE)) |=> !upd_go_q)
    else $error("Update started without a write.");

  AST_UPD_READBACK: assert property (
    (i_ce && i_reg_rd_en && i_reg_addr == `RXCFG_ADDR_UPDATE) |=> o_reg_rdata == {7'h00, $past(upd_bit_q)})
    else $error("Update bit read back wrong.");

  AST_APPLIED_FOLLOWS: assert property (
    (i_ce && upd_go_q) |=> o_update_applied)
    else $error("Update flag missing after trigger.");

  AST_APPLIED_ONE_CYCLE: assert property (
    (i_ce && o_update_applied) |=> !o_update_applied)
    else $error("Update flag held too long.");

  // Active set: gated words with calibration off, a faithful mode copy, and no drift between updates.
  AST_TRIM_OFF_ZERO: assert property (
    (i_ce && upd_go_q && !ctrl_q[`RXCFG_TRIM_EN_BIT]) |=> (o_i_gain_trim_word == 10'h000)
    && (o_q_gain_trim_word == 10'h000))
    else $error("Trim word applied with calibration off.");

  AST_MODE_COPY: assert property (
    (i_ce && upd_go_q) |=> o_adc_mode == $past(mode_d))
    else $error("Converter mode not copied on update.");

  AST_ACTIVE_HOLDS_ALL: assert property (
    (i_ce && !upd_go_q) |=> $stable(o_q_gain_trim_word) && $stable(o_adc_mode) && $stable(o_gain_trim_enable)
    && $stable(o_fine_trim_step) && $stable(o_aux_cml_enable) && $stable(o_i_cal_dac_enable)
    && $stable(o_q_cal_dac_enable))
    else $error("Active control changed without update.");

  // Clock enable low freezes the trigger, the flag, the read data and the synchroniser.
  AST_CE_FREEZE: assert property (
    !i_ce |=> $stable(upd_go_q) && $stable(o_update_applied) && $stable(o_reg_rdata) && $stable(lock_q))
    else $error("State moved while clock enable was low.");

  AST_LOCK_SYNC: assert property (
    i_ce |=> lock_q == $past(lock_meta_q))
    else $error("Lock synchroniser skipped a stage.");

  AST_RDATA_HOLDS: assert property (
    (i_ce && !i_reg_rd_en) |=> $stable(o_reg_rdata))
    else $error("Read data changed without a read.");

  // Covers mark the scenarios that the bench is expected to reach.
  COV_UPDATE: cover property (o_update_applied);
  COV_SINGLE_ADC: cover property (o_adc_mode == RXCFG_MODE_Q_ONLY);
  COV_TRIM_FINE: cover property (o_gain_trim_enable && o_fine_trim_step && o_i_gain_trim_word != 10'h000);
  COV_BOTH_LOCKED: cover property (lock_q == 2'h3);
  COV_CE_FROZEN: cover property (!i_ce && upd_bit_q);

endmodule : rxcfg_trim_regs
`default_nettype wire

// ### tb/rx_adc_trim_config_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_defines.svh"

module rx_adc_trim_config_registers_tb
  import rxcfg_pkg::*;
();
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, wr = 1'b0, rd = 1'b0, txl = 1'b0, rxl = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, o_reg_rdata;
  logic o_cmd, o_aux, o_en, o_fine, o_ical, o_qcal, o_upd;
  logic [9:0] o_iw, o_qw;
  logic [4:0] o_fs;
  rxcfg_adc_mode_t o_mode;
  logic [7:0] s_ctrl, s_ih, s_il, s_qh, s_ql, s_fs, s_mode;
  logic [32:0] a_exp;
  logic [31:0] rng = 32'h0000431f;
  int miscompares = 0, comparisons = 0;
  wire [32:0] act = {o_cmd, o_aux, o_en, o_fine, o_iw, o_qw, o_ical, o_qcal, o_fs, o_mode};

  rxcfg_trim_regs dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_wr_en(wr), .i_reg_rd_en(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_tx_delay_loop_locked(txl), .i_rx_delay_loop_locked(rxl),
    .o_reg_rdata(o_reg_rdata), .o_cm_buffer_disable(o_cmd), .o_aux_cml_enable(o_aux), .o_gain_trim_enable(o_en),
    .o_fine_trim_step(o_fine), .o_i_gain_trim_word(o_iw), .o_q_gain_trim_word(o_qw), .o_i_cal_dac_enable(o_ical),
    .o_q_cal_dac_enable(o_qcal), .o_full_scale_adjust(o_fs), .o_adc_mode(o_mode), .o_update_applied(o_upd));

  // System clock at 25 MHz.
  initial begin
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Xorshift source; a fixed seed keeps failures repeatable.
  function automatic logic [7:0] rnd8();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : rnd8

  // Active image expected after an update; trim words are gated while trim is off.
  function automatic logic [32:0] act_exp();
    logic en;
    en = s_ctrl[`RXCFG_TRIM_EN_BIT];
    return {s_ctrl[0], s_ctrl[4], en, s_ctrl[5], en ? {s_ih, s_il[2:1]} : 10'h000,
      en ? {s_qh, s_ql[2:1]} : 10'h000, s_il[0], s_ql[0], s_fs[4:0], (s_mode[1:0] == 2'h2) ? 2'h0 : s_mode[1:0]};
  endfunction : act_exp

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // A full idle cycle separates strobes, so no signal is driven twice in one step.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge i_sys_clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_sys_clk);
    rd = 1'b1;
    addr = a;
    @(negedge i_sys_clk);
    rd = 1'b0;
    chk({25'h0, o_reg_rdata}, {25'h0, exp}, "read data");
  endtask : rd_chk

  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the expected run of under two thousand cycles.
  initial begin
    repeat (6000) @(posedge i_sys_clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    a_exp = '0;
    chk(act, a_exp, "reset image");
    for (int k = 0; k < 8; k++) begin
      s_ctrl = (k == 0) ? 8'hff : rnd8();
      s_ctrl[6] = k[0];
      s_ih = (k == 0) ? 8'hff : rnd8();
      s_il = (k == 0) ? 8'hff : rnd8();
      s_qh = rnd8();
      s_ql = rnd8();
      s_fs = rnd8();
      s_mode = {rnd8() & 8'hfc} | {6'h00, k[1], k[2]};
      wr_reg(`RXCFG_ADDR_ADC_MODE, s_mode);
      wr_reg(`RXCFG_ADDR_FSADJ, s_fs);
      wr_reg(`RXCFG_ADDR_TRIM_CTRL, s_ctrl);
      wr_reg(`RXCFG_ADDR_I_TRIM_HI, s_ih);
      wr_reg(`RXCFG_ADDR_I_TRIM_LO, s_il);
      wr_reg(`RXCFG_ADDR_Q_TRIM_HI, s_qh);
      wr_reg(`RXCFG_ADDR_Q_TRIM_LO, s_ql);
      chk(act, a_exp, "staged only");
      rd_chk(`RXCFG_ADDR_TRIM_CTRL, s_ctrl & 8'h71);
      rd_chk(`RXCFG_ADDR_I_TRIM_LO, s_il & 8'h07);
      wr_reg(`RXCFG_ADDR_UPDATE, 8'h00);
      wr_reg(`RXCFG_ADDR_UPDATE, 8'h01);
      repeat (1) @(negedge i_sys_clk);
      a_exp = act_exp();
      chk({32'h0, o_upd}, 33'h1, "update pulse");
      chk(act, a_exp, "active image");
      s_qh = ~s_qh;
      wr_reg(`RXCFG_ADDR_Q_TRIM_HI, s_qh);
      wr_reg(`RXCFG_ADDR_UPDATE, 8'h01);
      repeat (1) @(negedge i_sys_clk);
      chk({32'h0, o_upd}, 33'h0, "repeated one");
      chk(act, a_exp, "held image");
      $display("test update %0d done", k);
    end
    // Lock inputs are asynchronous; three cycles covers the two-stage sync.
    for (int k = 0; k < 4; k++) begin
      @(negedge i_sys_clk);
      txl = k[1];
      rxl = k[0];
      repeat (3) @(negedge i_sys_clk);
      rd_chk(`RXCFG_ADDR_LOCK, {6'h00, k[1], k[0]});
    end
    wr_reg(`RXCFG_ADDR_LOCK, 8'h00);
    rd_chk(`RXCFG_ADDR_LOCK, 8'h03);
    rd_chk(8'h83, 8'h00);
    $display("test lock done");
    // Clock enable low must freeze everything, staged writes and the update edge included.
    @(negedge i_sys_clk);
    i_ce = 1'b0;
    wr_reg(`RXCFG_ADDR_TRIM_CTRL, ~s_ctrl);
    wr_reg(`RXCFG_ADDR_UPDATE, 8'h00);
    wr_reg(`RXCFG_ADDR_UPDATE, 8'h01);
    @(negedge i_sys_clk);
    chk({32'h0, o_upd}, 33'h0, "frozen pulse");
    chk(act, a_exp, "frozen image");
    i_ce = 1'b1;
    rd_chk(`RXCFG_ADDR_TRIM_CTRL, s_ctrl & 8'h71);
    rd_chk(`RXCFG_ADDR_UPDATE, 8'h01);
    $display("test clock enable done");
    // A second reset in mid-run must clear the active set and the staged registers alike.
    @(negedge i_sys_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'b0;
    a_exp = '0;
    chk(act, a_exp, "mid-run reset image");
    rd_chk(`RXCFG_ADDR_TRIM_CTRL, 8'h00);
    rd_chk(`RXCFG_ADDR_UPDATE, 8'h00);
    $display("test reset done");
    report_and_stop();
  end
endmodule : rx_adc_trim_config_registers_tb
`default_nettype wire
